// ==== rtl/clock_switch_failsafe_aux_clock.sv ====
// clock switch sequencer, fail-safe monitor and aux clock control
// assumes fuse and oscillator status pins are asynchronous to clk
// Function
// - aux divider source: aux osc or pll
// - aux osc mode: ext, crystal, hs, off
// - aux output divider 1..64, 000 is 256
// - aux reference: primary or aux osc
// - aux register power-on reset, unused bits zero
// - primary submode fixed by fuses only
// - switching and monitor need fuse zero
// - disabled: next ignored, current shows fuse
// - disabled: request bit ignored, reads zero
// - equal sources: clear request, abort switch
// - valid switch clears lock and fail flag
// - start new osc, wait timer or lock
// - count ten new-clock cycles before change
// - changeover clears request, copies latched target to current
// - stop old osc, except kept low_power_rc, secondary
// - processor keeps running during switch
// - monitor on keeps low_power_rc running always
// - failure raises trap, forces fast rc
// - pll in use: fall back fast rc pll
// - three-bit source code table
// - fail flag set by monitor, software clears
// - lock bit shows pll locked and enabled
`include "clock_switch_defs.svh"

module clock_switch_failsafe_aux_clock
    import clock_switch_pkg::*;
(
    // clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata_r,
    // fuses and oscillator status pins
    input  wire fuse_t       fuse_pins,
    input  wire osc_stat_t   stat_pins,
    // oscillator control
    output osc_en_t          osc_en_r,
    output logic      [2:0]  cur_r,
    output logic      [1:0]  primary_submode_r,
    output logic             trap_r,
    output logic             busy_r,
    // aux clock control
    output logic             aux_src_sel_r,
    output logic      [1:0]  aux_mode_r,
    output logic      [8:0]  aux_divisor_r,
    output logic             aux_ref_sel_r
);

    // ======================================================
    // functions
    // aux divider code to divide ratio
    function automatic logic [8:0] aux_divisor(input logic [2:0] code);
        case (code)
            3'h7:    aux_divisor = 9'h001;
            3'h6:    aux_divisor = 9'h002;
            3'h5:    aux_divisor = 9'h004;
            3'h4:    aux_divisor = 9'h008;
            3'h3:    aux_divisor = 9'h010;
            3'h2:    aux_divisor = 9'h020;
            3'h1:    aux_divisor = 9'h040;
            default: aux_divisor = 9'h100;
        endcase
    endfunction

    // oscillators a source needs running
    function automatic osc_en_t src_use(input logic [2:0] src);
        src_use = '0;
        case (src)
            `SRC_FRC, `SRC_FRC_DIV16, `SRC_FRC_DIVN: src_use.fast_rc = 1'b1;
            `SRC_FRC_PLL: begin
                src_use.fast_rc = 1'b1;
                src_use.pll = 1'b1;
            end
            `SRC_PRI:     src_use.pri = 1'b1;
            `SRC_PRI_PLL: begin
                src_use.pri = 1'b1;
                src_use.pll = 1'b1;
            end
            `SRC_SEC:     src_use.sec = 1'b1;
            default:      src_use.low_power_rc = 1'b1;
        endcase
    endfunction

    // ======================================================
    // pin synchronisers
    fuse_t     fuse_s1;
    fuse_t     fuse_s2;
    osc_stat_t stat_s1;
    osc_stat_t stat_s2;
    logic      fail_d_r;
    logic      new_clk_d_r;

    // two flops on every asynchronous pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fuse_s1 <= '0;
            fuse_s2 <= '0;
            stat_s1 <= '0;
            stat_s2 <= '0;
        end else begin
            fuse_s1 <= fuse_pins;
            fuse_s2 <= fuse_s1;
            stat_s1 <= stat_pins;
            stat_s2 <= stat_s1;
        end
    end

    // delayed copies for edge detection, read from stage two only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fail_d_r    <= 1'b0;
            new_clk_d_r <= 1'b0;
        end else begin
            fail_d_r    <= stat_s2.osc_fail;
            new_clk_d_r <= stat_s2.new_clk;
        end
    end

    // ======================================================
    // decoded conditions
    sw_state_t  state_r;
    sw_state_t  state_nxt;
    logic [2:0] next_r;
    logic [2:0] tgt_r;
    logic       req_r;
    logic       cf_r;
    logic       lock_r;
    logic       sec_en_r;
    logic       loaded_r;
    logic [1:0] settle_r;
    osc_en_t    cur_use;
    logic [3:0] cnt_r;
    logic [15:0] aux_r;
    logic       sw_en;
    logic       fail_safe_monitor_en;
    logic       fail_evt;
    logic       new_edge;
    logic       ready;
    logic       wr_aux;
    logic       wr_osc;
    logic       cf_clr;

    assign sw_en    = ~fuse_s2.switch_enable_fuse;
    assign fail_safe_monitor_en  = sw_en & ~fuse_s2.fail_safe_off_fuse;
    assign new_edge = stat_s2.new_clk & ~new_clk_d_r;
    assign cur_use  = src_use(cur_r);
    assign fail_evt = fail_safe_monitor_en & loaded_r & stat_s2.osc_fail & ~fail_d_r
                      & (cur_r != `SRC_FRC) & (cur_r != `SRC_FRC_PLL);
    assign wr_aux   = wr & (addr == `ADDR_AUX_CTRL);
    assign wr_osc   = wr & (addr == `ADDR_OSC_CTRL);
    assign cf_clr   = wr_osc & ~wdata[`OSC_FAIL_BIT];

    // new source ready: crystal waits for timer, pll for lock
    always_comb begin
        ready = 1'b1;
        if ((tgt_r == `SRC_SEC) ||
            (((tgt_r == `SRC_PRI) || (tgt_r == `SRC_PRI_PLL)) &&
             (fuse_s2.primary_osc_submode != `SUB_EXT_CLK))) begin
            ready = ready & stat_s2.startup_done;
        end
        if ((tgt_r == `SRC_FRC_PLL) || (tgt_r == `SRC_PRI_PLL)) begin
            ready = ready & stat_s2.pll_lock;
        end
    end

    // ======================================================
    // switch sequencer; cpu is never stalled by it
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (req_r && sw_en && !fail_evt && next_r != cur_r) begin
                    state_nxt = ST_START;
                end
            ST_START:  state_nxt = ST_WAIT;
            ST_WAIT:   if (ready) state_nxt = ST_COUNT;
            ST_COUNT:  if (cnt_r == `NEW_CLK_CYCLES) state_nxt = ST_SWITCH;
            ST_SWITCH: state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
        // a failure or losing the enable abandons any switch
        if (fail_evt || !sw_en) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) state_r <= ST_IDLE;
        else       state_r <= state_nxt;
    end

    // target latched at start so later next writes cannot steer it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)                   tgt_r <= `SRC_FRC;
        else if (state_r == ST_IDLE) tgt_r <= next_r;
    end

    // new-clock cycle counter, cleared outside the count state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
        end else if (state_r != ST_COUNT) begin
            cnt_r <= 4'h0;
        end else if (new_edge && cnt_r != `NEW_CLK_CYCLES) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // ======================================================
    // current source; fuse copy repeated every cycle until the synchroniser carries the
    // pins, else its reset zeros would stay as the initial source
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_r    <= `SRC_FRC;
            settle_r <= 2'b00;
            loaded_r <= 1'b0;
        end else begin
            settle_r <= {settle_r[0], 1'b1};
            loaded_r <= settle_r[1];
            if (!loaded_r || !sw_en) begin
                cur_r <= fuse_s2.initial_osc_fuse;
            end else if (fail_evt) begin
                cur_r <= cur_use.pll ? `SRC_FRC_PLL : `SRC_FRC;
            end else if (state_r == ST_SWITCH) begin
                cur_r <= tgt_r;
            end
        end
    end

    // request bit: set by software, cleared by hardware
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_r <= 1'b0;
        end else if (!sw_en) begin
            req_r <= 1'b0;
        end else if (state_r == ST_IDLE && req_r && next_r == cur_r) begin
            req_r <= 1'b0;
        end else if (state_r == ST_SWITCH || fail_evt) begin
            req_r <= 1'b0;
        end else if (wr_osc && wdata[`OSC_REQ_BIT]) begin
            req_r <= 1'b1;
        end
    end

    // next source and secondary enable, software fields
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            next_r   <= `SRC_FRC;
            sec_en_r <= 1'b0;
        end else if (wr_osc) begin
            next_r   <= wdata[`OSC_NEXT_HI:`OSC_NEXT_LO];
            sec_en_r <= wdata[`OSC_SEC_EN_BIT];
        end
    end

    // fail flag: a new failure wins over a software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cf_r <= 1'b0;
        end else if (fail_evt) begin
            cf_r <= 1'b1;
        end else if (state_r == ST_START || cf_clr) begin
            cf_r <= 1'b0;
        end
    end

    // lock status, forced low at switch start and with pll off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_r <= 1'b0;
        end else if (state_r == ST_START) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= osc_en_r.pll & stat_s2.pll_lock;
        end
    end

    // trap pulse and busy level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trap_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            trap_r <= fail_evt;
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // ======================================================
    // oscillator enables: current, target while switching, keepers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_en_r <= '0;
        end else begin
            osc_en_r <= src_use(cur_r)
                      | ((state_r != ST_IDLE) ? src_use(tgt_r) : '0)
                      | {1'b0, fail_safe_monitor_en | fuse_s2.watchdog_fuse,
                         sec_en_r, 2'b00};
        end
    end

    // primary submode follows the fuses, never software
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) primary_submode_r <= `SUB_EXT_CLK;
        else       primary_submode_r <= fuse_s2.primary_osc_submode;
    end

    // ======================================================
    // aux clock control register, power-on reset only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)       aux_r <= `AUX_CTRL_RESET;
        else if (wr_aux) aux_r <= wdata & `AUX_CTRL_MASK;
    end

    // aux control decoded to flopped outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_src_sel_r <= 1'b0;
            aux_mode_r    <= 2'h0;
            aux_divisor_r <= 9'h100;
            aux_ref_sel_r <= 1'b0;
        end else begin
            aux_src_sel_r <= aux_r[`AUX_SRC_BIT];
            aux_mode_r    <= aux_r[`AUX_MODE_HI:`AUX_MODE_LO];
            aux_divisor_r <= aux_divisor(aux_r[`AUX_DIV_HI:`AUX_DIV_LO]);
            aux_ref_sel_r <= aux_r[`AUX_REF_BIT];
        end
    end

    // ======================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else if (rd && addr == `ADDR_AUX_CTRL) begin
            rdata_r <= aux_r;
        end else if (rd && addr == `ADDR_OSC_CTRL) begin
            rdata_r <= {1'b0, cur_r, 1'b0, next_r, 2'b00, lock_r, 1'b0,
                        cf_r, 1'b0, sec_en_r, req_r & sw_en};
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // ======================================================
    // assertions
    sequence s_fail_seen;
        fail_evt;
    endsequence

    sequence s_fallback;
        (cur_r == `SRC_FRC || cur_r == `SRC_FRC_PLL) && trap_r;
    endsequence

    a_req_disabled: assert property (@(posedge clk) disable iff (!rstn)
        !sw_en |=> !req_r)
        else $error("request bit set while switching disabled");

    a_redundant_abort: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == ST_IDLE && req_r && next_r == cur_r && sw_en && loaded_r
         && !fail_evt) |=> (!req_r && $stable(cur_r) && state_r == ST_IDLE))
        else $error("redundant switch not aborted");

    a_start_clears: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == ST_START && !fail_evt) |=> (!cf_r && !lock_r))
        else $error("switch start left lock or fail flag set");

    a_count_ten: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == ST_SWITCH) |-> $past(cnt_r) == `NEW_CLK_CYCLES)
        else $error("changeover before ten new-clock cycles");

    a_switch_commit: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == ST_SWITCH && !fail_evt && sw_en)
        |=> (cur_r == $past(tgt_r) && !req_r))
        else $error("changeover did not commit source");

    a_fail_fallback: assert property (@(posedge clk) disable iff (!rstn)
        s_fail_seen |=> s_fallback)
        else $error("failure did not fall back to fast rc");

    a_fail_pll: assert property (@(posedge clk) disable iff (!rstn)
        (fail_evt && cur_use.pll && sw_en) |=> cur_r == `SRC_FRC_PLL)
        else $error("pll failure did not use fast rc pll");

    a_cf_set_wins: assert property (@(posedge clk) disable iff (!rstn)
        s_fail_seen |=> cf_r)
        else $error("fail flag lost");

    a_low_power_rc_kept: assert property (@(posedge clk) disable iff (!rstn)
        fail_safe_monitor_en |=> osc_en_r.low_power_rc)
        else $error("low_power_rc stopped with monitor on");

    a_disabled_cur: assert property (@(posedge clk) disable iff (!rstn)
        !sw_en |=> cur_r == $past(fuse_s2.initial_osc_fuse))
        else $error("current source not from fuse when disabled");

    a_aux_divider: assert property (@(posedge clk) disable iff (!rstn)
        (aux_r[`AUX_DIV_HI:`AUX_DIV_LO] == 3'h0) |=> aux_divisor_r == 9'h100)
        else $error("aux divider code zero not 256");

endmodule // clock_switch_failsafe_aux_clock

// ==== include/clock_switch_defs.svh ====
// constants for the clock switch, fail-safe monitor and aux clock control
// assumes a 16-bit register port addressed by word index
`ifndef CLOCK_SWITCH_DEFS_SVH
`define CLOCK_SWITCH_DEFS_SVH

// ==========================================================
// register indices
`define ADDR_AUX_CTRL        8'h00
`define ADDR_OSC_CTRL        8'h01

// ==========================================================
// aux clock control fields and reset
`define AUX_SRC_BIT          13
`define AUX_MODE_HI          12
`define AUX_MODE_LO          11
`define AUX_DIV_HI           10
`define AUX_DIV_LO           8
`define AUX_REF_BIT          7
`define AUX_CTRL_RESET       16'h0000
`define AUX_CTRL_MASK        16'h3F80

// ==========================================================
// osc control fields
`define OSC_CUR_HI           14
`define OSC_CUR_LO           12
`define OSC_NEXT_HI          10
`define OSC_NEXT_LO          8
`define OSC_LOCK_BIT         5
`define OSC_FAIL_BIT         3
`define OSC_SEC_EN_BIT       1
`define OSC_REQ_BIT          0

// ==========================================================
// oscillator source codes
`define SRC_FRC              3'h0
`define SRC_FRC_PLL          3'h1
`define SRC_PRI              3'h2
`define SRC_PRI_PLL          3'h3
`define SRC_SEC              3'h4
`define SRC_LOW_POWER_RC             3'h5
`define SRC_FRC_DIV16        3'h6
`define SRC_FRC_DIVN         3'h7

// primary submode codes
`define SUB_EXT_CLK          2'h0
`define SUB_CRYSTAL          2'h1
`define SUB_HS_CRYSTAL       2'h2

// ==========================================================
// timing
`define NEW_CLK_CYCLES       4'hA

`endif

// ==== include/clock_switch_pkg.sv ====
// types for the clock switch block
// assumes clock_switch_defs.svh is not needed here: types only
package clock_switch_pkg;

    // ======================================================
    // switch sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_WAIT   = 3'b010,
        ST_COUNT  = 3'b011,
        ST_SWITCH = 3'b100
    } sw_state_t;

    // configuration fuses as they arrive at the pins
    typedef struct packed {
        logic       switch_enable_fuse;
        logic       fail_safe_off_fuse;
        logic       watchdog_fuse;
        logic [2:0] initial_osc_fuse;
        logic [1:0] primary_osc_submode;
    } fuse_t;

    // status from the analog oscillators, pll and start-up timer
    typedef struct packed {
        logic startup_done;
        logic pll_lock;
        logic osc_fail;
        logic new_clk;
    } osc_stat_t;

    // oscillator enables {pll, low_power_rc, secondary, primary, frc}
    typedef struct packed {
        logic pll;
        logic low_power_rc;
        logic sec;
        logic pri;
        logic fast_rc;
    } osc_en_t;

endpackage

// ==== bench/clock_switch_failsafe_aux_clock_tb_top.sv ====
// self-checking bench for the clock switch, fail-safe monitor and aux clock control
// assumes the package and defs header are compiled first; one 20 MHz clock
`include "clock_switch_defs.svh"

module clock_switch_failsafe_aux_clock_tb_top
    import clock_switch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // stimulus and observed signals
    logic        clk;
    logic        rstn;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata_r;
    fuse_t       fuse;
    osc_stat_t   stat;
    osc_en_t     osc_en_r;
    logic [2:0]  cur_r;
    logic [1:0]  sub_r;
    logic        trap_r;
    logic        busy_r;
    logic        aux_src_sel_r;
    logic [1:0]  aux_mode_r;
    logic [8:0]  aux_divisor_r;
    logic        aux_ref_sel_r;
    int          failures;
    int          total_checks;

    clock_switch_failsafe_aux_clock i_clock_switch_failsafe_aux_clock (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .fuse_pins(fuse), .stat_pins(stat), .osc_en_r(osc_en_r),
        .cur_r(cur_r), .primary_submode_r(sub_r), .trap_r(trap_r), .busy_r(busy_r),
        .aux_src_sel_r(aux_src_sel_r), .aux_mode_r(aux_mode_r),
        .aux_divisor_r(aux_divisor_r), .aux_ref_sel_r(aux_ref_sel_r)
    );

    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // strobes are one cycle; a gap cycle follows so no signal is assigned twice per step
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe is sampled
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata_r;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for the system clock select to leave a source
    task automatic wait_cur_change(input logic [2:0] old, output int n);
        n = 0;
        while (cur_r === old && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_aux;
        logic [15:0] v;
        logic [15:0] d;
        logic [8:0]  dv;
        for (int i = 0; i < 8; i++) begin
            d  = {2'b11, i[0], i[1:0], i[2:0], ~i[0], 7'h7F};
            dv = (i == 0) ? 9'h100 : 9'(1 << (7 - i));
            reg_wr(8'h00, d);
            reg_rd(8'h00, v);
            check(v, d & 16'h3F80);
            check(16'(aux_src_sel_r), 16'(i[0]));
            check(16'(aux_mode_r), 16'(i[1:0]));
            check(16'(aux_divisor_r), 16'(dv));
            check(16'(aux_ref_sel_r), {15'h0000, ~i[0]});
        end
        reg_wr(8'h05, 16'h0000);
        reg_rd(8'h00, v);
        check(v, 16'h3F00);
        reg_rd(8'h05, v);
        check(v, 16'h0000);
    endtask

    task automatic t_disabled;
        logic [15:0] v;
        @(posedge clk);
        fuse.initial_osc_fuse <= `SRC_LOW_POWER_RC;
        cycles(6);
        check(16'(cur_r), 16'(`SRC_LOW_POWER_RC));
        reg_wr(8'h01, {5'h00, `SRC_PRI, 8'h09});
        cycles(20);
        check(16'(cur_r), 16'(`SRC_LOW_POWER_RC));
        check(16'(busy_r), 16'h0000);
        reg_rd(8'h01, v);
        check(16'(v[0]), 16'h0000);
        @(posedge clk);
        fuse.initial_osc_fuse <= `SRC_FRC;
        cycles(6);
        check(16'(cur_r), 16'(`SRC_FRC));
        // fuses are fixed in silicon; enable only once the source has settled
        @(posedge clk);
        fuse.switch_enable_fuse <= 1'b0;
        cycles(6);
        check(16'(cur_r), 16'(`SRC_FRC));
    endtask

    task automatic t_redundant;
        logic [15:0] v;
        reg_wr(8'h01, {5'h00, `SRC_FRC, 8'h09});
        cycles(8);
        reg_rd(8'h01, v);
        check(16'(v[0]), 16'h0000);
        check(16'(cur_r), 16'(`SRC_FRC));
    endtask

    task automatic t_to_primary;
        logic [15:0] v;
        int          n;
        reg_wr(8'h01, {5'h00, `SRC_PRI, 8'h09});
        cycles(40);
        check(16'(busy_r), 16'h0001);
        check(16'(cur_r), 16'(`SRC_FRC));
        @(posedge clk);
        stat.startup_done <= 1'b1;
        wait_cur_change(`SRC_FRC, n);
        // new clock toggles every 4 cycles, so ten rising edges span at least 72
        check(16'(n >= 72), 16'h0001);
        check(16'(cur_r), 16'(`SRC_PRI));
        cycles(2);
        reg_rd(8'h01, v);
        check({v[14:12], v[0]}, {`SRC_PRI, 1'b0});
        check(16'({osc_en_r.pri, osc_en_r.fast_rc}), 16'h0002);
        check(16'(osc_en_r.low_power_rc), 16'h0001);
        check(16'(sub_r), 16'(`SUB_CRYSTAL));
    endtask

    task automatic t_fail(input logic [2:0] exp);
        logic [15:0] v;
        int          n;
        @(posedge clk);
        stat.osc_fail <= 1'b1;
        n = 0;
        while (trap_r !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(trap_r), 16'h0001);
        check(16'(cur_r), 16'(exp));
        cycles(1);
        check(16'(trap_r), 16'h0000);
        @(posedge clk);
        stat.osc_fail <= 1'b0;
        reg_rd(8'h01, v);
        check(16'({v[3], busy_r}), 16'h0002);
    endtask

    task automatic t_to_pll;
        logic [15:0] v;
        int          n;
        // flag bit written as one so the write itself does not clear it
        reg_wr(8'h01, {5'h00, `SRC_PRI_PLL, 8'h09});
        cycles(30);
        reg_rd(8'h01, v);
        check(16'({v[5], v[3]}), 16'h0000);
        check(16'({busy_r, cur_r}), 16'({1'b1, `SRC_FRC}));
        @(posedge clk);
        stat.pll_lock <= 1'b1;
        wait_cur_change(`SRC_FRC, n);
        check(16'(cur_r), 16'(`SRC_PRI_PLL));
        cycles(2);
        reg_rd(8'h01, v);
        check(16'(v[5]), 16'h0001);
        check(16'(osc_en_r.pll), 16'h0001);
    endtask

    task automatic t_clear_flag;
        logic [15:0] v;
        // stays on the fallback: next written equal to the current source, request bit zero
        reg_wr(8'h01, {5'h00, `SRC_FRC_PLL, 8'h00});
        reg_rd(8'h01, v);
        check(16'({v[14:12], v[3]}), 16'({`SRC_FRC_PLL, 1'b0}));
    endtask

    // ==========================================================
    // clock, link-side new clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        forever begin
            repeat (4) @(posedge clk);
            stat.new_clk <= ~stat.new_clk;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        logic [15:0] v;
        failures     = 0;
        total_checks = 0;
        rstn  = 1'b0;
        addr  = 8'h00;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
        stat  = '0;
        fuse  = '{1'b1, 1'b0, 1'b0, `SRC_FRC, `SUB_CRYSTAL};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        cycles(4);
        check(16'(aux_divisor_r), 16'h0100);
        check(16'(aux_mode_r), 16'h0000);
        reg_rd(8'h00, v);
        check(v, 16'h0000);
        t_aux();
        t_disabled();
        t_redundant();
        t_to_primary();
        t_fail(`SRC_FRC);
        t_to_pll();
        t_fail(`SRC_FRC_PLL);
        t_clear_flag();
        test_done();
    end

endmodule // clock_switch_failsafe_aux_clock_tb_top
